// ---- ssl_serial_load.sv ----
// serial load path, latch decode and reset / power-down sequencing
// assumes serial pins come from another clock domain; cp_event is on aclk
`timescale 1ns/1ns
module ssl_serial_load
    import ssl_pkg::*;
(
    input wire logic aclk, // system clock, 10 mhz
    input wire logic aresetn, // sync reset, active low
    input wire logic serial_clk, // serial clock pin
    input wire logic serial_data, // serial data pin
    input wire logic latch_strobe, // latch strobe pin
    input wire logic power_enable, // power enable pin, high = run
    input wire logic cp_event, // charge pump event pulse, aclk domain
    output logic [WORD_W-1:0] ref_latch, // reference counter latch
    output logic [WORD_W-1:0] ab_latch, // ab counter latch
    output logic [WORD_W-1:0] func_latch, // function latch
    output logic counter_reset, // counters held at load state
    output logic cp_three_state, // charge pump forced three-state
    output logic power_down, // device powered down
    output logic prescaler_run, // prescaler reference and osc buffer on
    output logic bias_settled, // settling time elapsed since enable
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    typedef struct packed {
        logic [WORD_W-1:0] shift;
        logic [WORD_W-1:0] ref_word;
        logic [WORD_W-1:0] ab_word;
        logic [WORD_W-1:0] func_word;
        logic sclk_q;
        logic strobe_q;
        logic [7:0] pulse_len;
        logic [7:0] pulse_cnt;
        logic init_armed;
        logic sync_pd;
        logic [3:0] loaded;
        logic [SETTLE_W-1:0] settle_cnt;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ssl_state_t;

    localparam logic [SETTLE_W-1:0] SETTLE_END = SETTLE_W'(SETTLE_CYC);

    ssl_state_t st;
    ssl_state_t next_st;
    logic [3:0] pins_s;
    logic sclk_s;
    logic sdata_s;
    logic strobe_s;
    logic pe_s;
    logic pulse_on;
    logic hold_on;
    logic async_pd;
    logic pdown;
    logic [31:0] status_word;
    ssl_reg_t rd_sel;
    ssl_reg_t wr_sel;

    // word-aligned address decode, shared by both channels
    function automatic ssl_reg_t decode(input logic [ADDR_W-1:0] a);
        ssl_reg_t r;
        r = SSL_R_NONE;
        unique case (a)
            OFS_REF: r = SSL_R_REF;
            OFS_AB: r = SSL_R_AB;
            OFS_FUNC: r = SSL_R_FUNC;
            OFS_STATUS: r = SSL_R_STATUS;
            OFS_PULSE: r = SSL_R_PULSE;
            default: r = SSL_R_NONE;
        endcase
        return r;
    endfunction : decode

    ssl_sync #(
        .W(4)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({power_enable, latch_strobe, serial_data, serial_clk}),
        .q(pins_s)
    );

    assign sclk_s = pins_s[0];
    assign sdata_s = pins_s[1];
    assign strobe_s = pins_s[2];
    assign pe_s = pins_s[3];

    assign pulse_on = st.pulse_cnt != '0;
    assign hold_on = st.func_word[HOLD_POS];
    // programmed modes only count while the enable pin is high
    assign async_pd = pe_s && st.func_word[PD_REQ_POS] && !st.func_word[PD_SYNC_POS];
    // pin low wins over everything; latency is the synchroniser only
    assign pdown = !pe_s || async_pd || st.sync_pd;

    assign status_word = {
        20'h00000,
        st.loaded,
        2'h0,
        (st.settle_cnt == SETTLE_END),
        st.sync_pd,
        st.init_armed,
        pulse_on,
        (pulse_on || hold_on || pdown),
        pdown
    };

    assign rd_sel = decode(s_axi_araddr);
    assign wr_sel = decode(st.aw_addr);

    always_comb begin
        next_st = st;
        next_st.sclk_q = sclk_s;
        next_st.strobe_q = strobe_s;

        // input register shifts regardless of power state
        if (sclk_s && !st.sclk_q) begin
            next_st.shift = {st.shift[WORD_W-2:0], sdata_s};
        end

        if (pulse_on) begin
            next_st.pulse_cnt = st.pulse_cnt - 8'h01;
        end

        // sync power-down waits for a charge pump event; the hold bit never starts it
        // it ends only when the pin or the request bit drops, so an init entry stays
        if (!(pe_s && st.func_word[PD_REQ_POS])) begin
            next_st.sync_pd = 1'b0;
        end else if (cp_event && st.func_word[PD_SYNC_POS]) begin
            next_st.sync_pd = 1'b1;
        end

        if (strobe_s && !st.strobe_q) begin
            unique case (st.shift[1:0])
                SEL_REF: begin
                    next_st.ref_word = st.shift;
                    next_st.loaded[LD_REF] = 1'b1;
                end
                SEL_AB: begin
                    next_st.ab_word = st.shift;
                    next_st.loaded[LD_AB] = 1'b1;
                    if (st.init_armed) begin
                        next_st.pulse_cnt = st.pulse_len;
                        next_st.init_armed = 1'b0;
                    end
                end
                SEL_FUNC: begin
                    next_st.func_word = st.shift;
                    next_st.loaded[LD_FUNC] = 1'b1;
                end
                SEL_INIT: begin
                    next_st.func_word = st.shift;
                    next_st.loaded[LD_INIT] = 1'b1;
                    next_st.pulse_cnt = st.pulse_len;
                    next_st.init_armed = 1'b1;
                    // the pulse itself triggers power-down for request set, sync select clear
                    if (pe_s && st.shift[PD_REQ_POS] && !st.shift[PD_SYNC_POS]) begin
                        next_st.sync_pd = 1'b1;
                    end
                end
            endcase
        end

        // bias settle timer restarts on every enable pin low
        if (!pe_s) begin
            next_st.settle_cnt = '0;
        end else if (st.settle_cnt != SETTLE_END) begin
            next_st.settle_cnt = st.settle_cnt + SETTLE_W'(1);
        end

        // write channel: address and data taken in either order
        if (s_axi_awvalid && !st.aw_held && !st.bvalid) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_held && !st.bvalid) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            unique case (wr_sel)
                SSL_R_PULSE: begin
                    if (st.w_strb[0]) begin
                        // a zero length would lose the pulse entirely
                        next_st.pulse_len = (st.w_data[7:0] == 8'h00) ?
                            PULSE_LEN_MIN : st.w_data[7:0];
                    end
                end
                SSL_R_NONE: next_st.bresp = RESP_SLVERR;
                default: next_st.bresp = RESP_OKAY;
            endcase
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // read channel
        if (st.rvalid) begin
            if (s_axi_rready) begin
                next_st.rvalid = 1'b0;
            end
        end else if (s_axi_arvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            unique case (rd_sel)
                SSL_R_REF: next_st.rdata = {8'h00, st.ref_word};
                SSL_R_AB: next_st.rdata = {8'h00, st.ab_word};
                SSL_R_FUNC: next_st.rdata = {8'h00, st.func_word};
                SSL_R_STATUS: next_st.rdata = status_word;
                SSL_R_PULSE: next_st.rdata = {24'h000000, st.pulse_len};
                SSL_R_NONE: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // latches are cleared only by aresetn, never by the enable pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.pulse_len <= PULSE_LEN_RST;
        end else begin
            st <= next_st;
        end
    end

    assign ref_latch = st.ref_word;
    assign ab_latch = st.ab_word;
    assign func_latch = st.func_word;
    // counters restart aligned as soon as hold, pulse and power-down all drop
    assign counter_reset = pulse_on || hold_on || pdown;
    assign cp_three_state = pulse_on || hold_on || pdown;
    // the reset pulse is deliberately absent here
    assign prescaler_run = !pdown;
    assign power_down = pdown;
    assign bias_settled = st.settle_cnt == SETTLE_END;

    assign s_axi_awready = !st.aw_held && !st.bvalid;
    assign s_axi_wready = !st.w_held && !st.bvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
endmodule : ssl_serial_load

// ---- ssl_pkg.sv ----
// constants, field layout and register map of the serial load and init block
// assumes a 10 mhz system clock and 32-bit axi4-lite register access
package ssl_pkg;
    localparam int WORD_W = 24;
    localparam int CLK_NS = 100;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_W = 4;

    // destination select in the two lsbs of the loaded word
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_AB = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;

    // function word field positions
    localparam int HOLD_POS = 2;
    localparam int PD_REQ_POS = 3;
    localparam int PD_SYNC_POS = 21;

    // loaded-flag positions
    localparam int LD_REF = 0;
    localparam int LD_AB = 1;
    localparam int LD_FUNC = 2;
    localparam int LD_INIT = 3;

    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_REF = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_AB = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FUNC = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_PULSE = 8'h10;

    localparam logic [7:0] PULSE_LEN_RST = 8'h04;
    localparam logic [7:0] PULSE_LEN_MIN = 8'h01;

    // status register bit positions
    localparam int ST_PDOWN = 0;
    localparam int ST_CRESET = 1;
    localparam int ST_PULSE = 2;
    localparam int ST_ARMED = 3;
    localparam int ST_SYNCPD = 4;
    localparam int ST_SETTLED = 5;
    localparam int ST_LOADED = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SSL_R_REF, SSL_R_AB, SSL_R_FUNC, SSL_R_STATUS, SSL_R_PULSE, SSL_R_NONE
    } ssl_reg_t;
endpackage : ssl_pkg

// ---- ssl_sync.sv ----
// two-flop level synchroniser for a group of pins
// assumes the pins are quasi-static relative to aclk
`timescale 1ns/1ns
module ssl_sync #(
    parameter int W = 1
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [W-1:0] d, // asynchronous pins
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta;

    // meta is read only by q
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : ssl_sync

// ---- ssl_sva.sv ----
// port-level checker for the serial load and init block
// assumes it is bound to ssl_serial_load and sees only its ports
`timescale 1ns/1ns
module ssl_sva
    import ssl_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic latch_strobe, // latch strobe pin
    input wire logic power_enable, // power enable pin
    input wire logic [WORD_W-1:0] ref_latch, // reference latch
    input wire logic [WORD_W-1:0] ab_latch, // ab latch
    input wire logic [WORD_W-1:0] func_latch, // function latch
    input wire logic counter_reset, // counters held
    input wire logic cp_three_state, // pump three-state
    input wire logic power_down, // powered down
    input wire logic prescaler_run, // prescaler on
    input wire logic bias_settled // settling elapsed
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pump_follows: assert property (cp_three_state == counter_reset)
        else $error("pump three-state differs from counter reset");
    a_prescaler_kept: assert property (prescaler_run != power_down)
        else $error("prescaler state wrong");
    a_pd_holds_counters: assert property (power_down |-> counter_reset)
        else $error("power-down without counter reset");
    a_hold_bit: assert property (func_latch[HOLD_POS] |-> counter_reset)
        else $error("hold bit set but counters run");
    // latches may move only a few cycles after a strobe rise
    a_latch_quiet: assert property ((!latch_strobe)[*6] |=>
        $stable(ref_latch) && $stable(ab_latch) && $stable(func_latch))
        else $error("latch changed without strobe");
    a_enable_off: assert property ((!power_enable)[*4] |-> power_down && !bias_settled)
        else $error("enable low but not powered down");
    a_pd_gated: assert property ((power_enable && !func_latch[PD_REQ_POS])[*5] |->
        !power_down)
        else $error("power-down with request bit clear");
    a_settle_time: assert property (power_enable[*8] ##1 power_enable[*8] |->
        bias_settled)
        else $error("bias not settled after enable");
endmodule : ssl_sva

// ---- ssl_host.sv ----
// host model driving the serial clock, data and latch strobe pins
// assumes it is the only driver of these pins; clock idles low between words
`timescale 1ns/1ns
module ssl_host (
    output logic serial_clk, // serial clock pin
    output logic serial_data, // serial data pin
    output logic latch_strobe // latch strobe pin
);
    initial begin
        serial_clk = 1'h0;
        serial_data = 1'h0;
        latch_strobe = 1'h0;
    end
    task automatic send(input logic [23:0] w);
        // keep every pin change away from the aclk edges
        #25;
        for (int i = 23; i >= 0; i--) begin
            serial_data = w[i];
            #200 serial_clk = 1'h1;
            #400 serial_clk = 1'h0;
            #200;
        end
        // released data shows the inverse so a stale bit cannot pass
        serial_data = ~w[0];
        latch_strobe = 1'h1;
        #800 latch_strobe = 1'h0;
        #800;
    endtask : send
endmodule : ssl_host

// ---- ssl_serial_load_bench.sv ----
// self-checking bench for the serial load and init block
// assumes ssl_pkg, the design, ssl_host and ssl_sva are compiled before it
`timescale 1ns/1ns
module ssl_serial_load_bench
    import ssl_pkg::*;
;
    logic aclk = 1'h0, aresetn = 1'h0, power_enable = 1'h0, cp_event = 1'h0;
    logic serial_clk, serial_data, latch_strobe;
    logic [WORD_W-1:0] ref_latch, ab_latch, func_latch;
    logic counter_reset, cp_three_state, power_down, prescaler_run, bias_settled;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_errors = 0, n_tests = 0, cyc = 0;
    logic [65:0] exp_q[$]; // resp, mask, data
    logic [1:0] exp_b[$]; // expected write responses
    logic [15:0] lf = 16'h000c;
    logic [23:0] mv[3]; // expected latch contents by select

    always #50 aclk = ~aclk;

    ssl_serial_load i_ssl_serial_load (.aclk, .aresetn, .serial_clk, .serial_data,
        .latch_strobe, .power_enable, .cp_event, .ref_latch, .ab_latch, .func_latch,
        .counter_reset, .cp_three_state, .power_down, .prescaler_run, .bias_settled,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    ssl_host i_ssl_host (.serial_clk, .serial_data, .latch_strobe);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic err(input string m);
        n_errors++;
        $display("ERROR %0t %s", $time, m);
    endtask : err
    task automatic cmp_rd(input logic [65:0] e, input logic [33:0] g);
        n_tests++;
        if ((({e[65:64], e[31:0]} ^ g) & {2'h3, e[63:32]}) !== 34'h0) err("read mismatch");
    endtask : cmp_rd
    task automatic cmp_b(input logic [1:0] e, input logic [1:0] g);
        n_tests++;
        if (g !== e) err("write response mismatch");
    endtask : cmp_b
    task automatic cmp_lat(input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) err("latch port mismatch");
    endtask : cmp_lat
    task automatic cmp_v(input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) err("pulse length mismatch");
    endtask : cmp_v
    task automatic conclude;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        exp_q.push_back({r, m, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask : rd
    // b = {sync select, request, hold} bits; ep 8'hff skips the pulse count
    task automatic ld(input logic [1:0] sel, input logic [2:0] b, input logic [7:0] ep);
        logic [23:0] w;
        logic [7:0] n;
        logic [1:0] d;
        lf = lfsr(lfsr(lf));
        w = {lf[15:14], b[2], lf[12:0], lf[7:4], b[1], b[0], sel};
        d = (sel == SEL_INIT) ? SEL_FUNC : sel;
        n = 8'h0;
        fork
            i_ssl_host.send(w);
            repeat (300) begin
                @(posedge aclk);
                if (counter_reset) n++;
            end
        join
        if (ep != 8'hff) cmp_v(ep, n);
        cmp_lat(w, (d == SEL_REF) ? ref_latch :
            (d == SEL_AB) ? ab_latch : func_latch);
        mv[d] = w;
        rd({4'h0, d, 2'h0}, 32'hffffffff, {8'h0, w});
    endtask : ld

    always @(posedge aclk) begin
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            if (exp_q.size() == 0) err("unexpected read");
            else cmp_rd(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        if (aresetn && s_axi_bvalid && s_axi_bready) begin
            if (exp_b.size() == 0) err("unexpected write response");
            else cmp_b(exp_b.pop_front(), s_axi_bresp);
        end
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err("timeout");
            conclude();
        end
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 3; i++) rd({4'h0, 2'(i), 2'h0}, 32'hffffffff, 32'h0);
        rd(OFS_STATUS, 32'h00000f3f, 32'h00000003);
        rd(OFS_PULSE, 32'hffffffff, {24'h0, PULSE_LEN_RST});
        rd(8'h14, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(8'h14, 32'h1, RESP_SLVERR);
        wr(OFS_REF, 32'h5, RESP_OKAY);
        rd(OFS_REF, 32'hffffffff, 32'h0);
        wr(OFS_PULSE, 32'h0, RESP_OKAY);
        rd(OFS_PULSE, 32'hffffffff, {24'h0, PULSE_LEN_MIN});
        wr(OFS_PULSE, 32'h6, RESP_OKAY);
        $display("test 1 register map done");
        power_enable <= 1'h1;
        repeat (20) @(posedge aclk);
        ld(SEL_INIT, 3'h0, 8'h06);
        rd(OFS_STATUS, 32'h00000808, 32'h00000808);
        ld(SEL_FUNC, 3'h0, 8'h00);
        ld(SEL_REF, 3'h0, 8'h00);
        ld(SEL_AB, 3'h0, 8'h06);
        ld(SEL_AB, 3'h0, 8'h00);
        rd(OFS_STATUS, 32'h00000f3f, 32'h00000f20);
        $display("test 2 init method done");
        ld(SEL_FUNC, 3'h1, 8'hff);
        rd(OFS_STATUS, 32'h13, 32'h02);
        ld(SEL_REF, 3'h0, 8'hff);
        ld(SEL_AB, 3'h0, 8'hff);
        ld(SEL_FUNC, 3'h0, 8'hff);
        rd(OFS_STATUS, 32'h13, 32'h00);
        $display("test 3 counter hold done");
        ld(SEL_FUNC, 3'h6, 8'hff);
        rd(OFS_STATUS, 32'h11, 32'h00);
        cp_event <= 1'h1;
        @(posedge aclk);
        cp_event <= 1'h0;
        rd(OFS_STATUS, 32'h11, 32'h11);
        ld(SEL_FUNC, 3'h0, 8'hff);
        rd(OFS_STATUS, 32'h11, 32'h00);
        ld(SEL_INIT, 3'h2, 8'hff);
        rd(OFS_STATUS, 32'h13, 32'h13);
        ld(SEL_REF, 3'h0, 8'hff);
        ld(SEL_FUNC, 3'h0, 8'hff);
        $display("test 4 power-down modes done");
        power_enable <= 1'h0;
        repeat (4) @(posedge aclk);
        rd(OFS_STATUS, 32'h23, 32'h03);
        ld(SEL_AB, 3'h0, 8'hff);
        power_enable <= 1'h1;
        repeat (5) @(posedge aclk);
        rd(OFS_STATUS, 32'h20, 32'h00);
        repeat (20) @(posedge aclk);
        rd(OFS_STATUS, 32'h23, 32'h20);
        for (int i = 0; i < 3; i++) begin
            rd({4'h0, 2'(i), 2'h0}, 32'hffffffff, {8'h0, mv[i]});
        end
        $display("test 5 enable pin method done");
        conclude();
    end
endmodule : ssl_serial_load_bench

bind ssl_serial_load ssl_sva i_ssl_sva (.aclk, .aresetn, .latch_strobe, .power_enable,
    .ref_latch, .ab_latch, .func_latch, .counter_reset, .cp_three_state, .power_down,
    .prescaler_run, .bias_settled);
